// ===== src/rswr_map.svh
`ifndef RSWR_MAP_SVH
`define RSWR_MAP_SVH

// register byte offsets
`define RSWR_A_CTRL   8'h00
`define RSWR_A_CW0    8'h04
`define RSWR_A_CW1    8'h08
`define RSWR_A_CW2    8'h0C
`define RSWR_A_CW3    8'h10
`define RSWR_A_CW4    8'h14
`define RSWR_A_IOB    8'h18
`define RSWR_A_CFG    8'h1C
`define RSWR_A_STAT   8'h20
`define RSWR_A_DATA   8'h24
`define RSWR_A_SCAN   8'h28
`define RSWR_A_ERRC   8'h2C

// control and status register fields
`define RSWR_CTRL_GO     0
`define RSWR_CTRL_REWIND 1
`define RSWR_CMD_WRITE   8'h01
`define RSWR_STAT_OPF    3

// configuration: b0 intelligent, b1 special, b2 older target, b31:16 size
`define RSWR_CFG_RST  32'h01E0_0003
`define RSWR_CFG_IFM  0
`define RSWR_CFG_SFM  1
`define RSWR_CFG_OLD  2

// limits
`define RSWR_MAX_CNT  480
`define RSWR_OLD_CNT  16'h000A
`define RSWR_MAX_STN  16'h0040
`define RSWR_IOB_MAX  16'h00FE
`define RSWR_HDR_LEN  10'h004

// error codes
`define RSWR_EC_NOT_IFM 16'h0110
`define RSWR_EC_NOT_SFM 16'h2112
`define RSWR_EC_UNSUP   16'h4002
`define RSWR_EC_OPCNT   16'h4003
`define RSWR_EC_BADDEV  16'h4004
`define RSWR_EC_BADDAT  16'h4100
`define RSWR_EC_RANGE   16'h4101
`define RSWR_EC_REMOTE  16'h4A00

// attribute codes
`define RSWR_ATR_BUF  8'h04
`define RSWR_ATR_DEV  8'h05

// buffer access codes
`define RSWR_B_IDS    8'h00
`define RSWR_B_RAND   8'h20
`define RSWR_B_RIN    8'h21
`define RSWR_B_ROUT   8'h22
`define RSWR_B_RREG   8'h24
`define RSWR_B_LSR    8'h63
`define RSWR_B_LSW    8'h64

// device access codes, bit type
`define RSWR_D_IN     8'h01
`define RSWR_D_OUT    8'h02
`define RSWR_D_MREL   8'h03
`define RSWR_D_LAT    8'h83
`define RSWR_D_LREL   8'h23
`define RSWR_D_TCON   8'h09
`define RSWR_D_TCOIL  8'h0A
`define RSWR_D_RTCON  8'h89
`define RSWR_D_RTCOIL 8'h8A
`define RSWR_D_CCON   8'h11
`define RSWR_D_CCOIL  8'h12
`define RSWR_D_SREL   8'h43
// device access codes, word type
`define RSWR_D_TPV    8'h0C
`define RSWR_D_RTPV   8'h8C
`define RSWR_D_CPV    8'h14
`define RSWR_D_DREG   8'h04
`define RSWR_D_LREG   8'h24
`define RSWR_D_FREG   8'h84
`define RSWR_D_SREG   8'h44

`endif

// ===== src/rswr_pkg.sv
package rswr_pkg;

	typedef enum logic [1:0] {RSWR_IDLE, RSWR_SEND, RSWR_WAIT} rswr_state_e;

	// one word toward the station
	typedef struct packed {
		logic        valid;
		logic        last;
		logic [15:0] word;
	} rswr_link_s;

	// whole state of the engine
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		logic [15:0] cw0, cw1, cw2, cw3, cw4, iob;
		logic [31:0] cfg;
		logic [7:0]  cmd;
		logic [9:0]  wptr;
		logic [9:0]  idx;
		rswr_state_e fsm;
		rswr_link_s  lk;
		logic [1:0]  rdy_sy, rv_sy, re_sy;
		logic        rv_d;
		logic        busy, pend, pend_err, done, err, opf;
		logic [15:0] opc;
	} rswr_regs_s;

endpackage

// ===== src/rswr_top.sv
`timescale 1ns/1ns
`include "rswr_map.svh"
// Overview of operation
// RULE1: finished command leaves zero or error code in control word 0
// RULE2: requester puts station 0..64 in control word 1
// RULE3: word 2 holds access code high byte, attribute low byte
// RULE4: word 3 holds start; random buffer offsets count from 0
// RULE5: word 4 count 1..480, within buffer and send size
// RULE6: older controller device write limited to 1..10 words
// RULE7: attribute 04h picks buffers by access code
// RULE8: attribute 05h picks controller device areas by access code
// RULE9: unknown access and attribute pairs are rejected
// RULE10: bit device start is zero or multiple of 16
// RULE11: write data is staged in the send buffer first
// RULE12: staged data goes to station with codes and start
// RULE13: station answers write complete after storing
// RULE14: done only after the write complete answer arrives
// RULE15: one outstanding write per station
// RULE16: done rises at a scan end, falls at the next
// RULE17: error pulses with done on abnormal finish only
// RULE18: invalid command sets error flag and error code
// RULE19: codes 0110 and 2112 for wrong module kind
// RULE20: codes 4002, 4003, 4004 for command and operand faults
// RULE21: codes 4100 and 4101 for bad data and range
// RULE22: module base is 0..FEh in 16 bits
// RULE23: status word settles no later than the done pulse
module rswr_top #(
	parameter int MAXW = `RSWR_MAX_CNT
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output wire logic        wb_ack_o,
	output wire logic [31:0] wb_dat_o,
	output wire logic        link_valid,
	output wire logic        link_last,
	output wire logic [15:0] link_word,
	input  wire logic        link_ready,
	input  wire logic        resp_valid,
	input  wire logic        resp_err,
	output wire logic        cmd_done,
	output wire logic        cmd_error,
	output wire logic        op_error,
	output wire logic        busy
);

	localparam int AW = $clog2(MAXW);

	rswr_pkg::rswr_regs_s s_ff;
	rswr_pkg::rswr_regs_s nxt_s;
	logic [15:0] sbuf [0:MAXW-1];
	logic        req;
	logic        go;
	logic        scan_w;
	logic        buf_we;
	logic [15:0] chk_code;
	logic [AW-1:0] ridx;

	// byte-lane merge of a write into a register
	function automatic logic [31:0] merge(logic [31:0] old,
		logic [31:0] nw, logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// {known pair, bit device} for access and attribute codes
	function automatic logic [1:0] kind(logic [7:0] atr, logic [7:0] acc);
		logic [1:0] k;
		k = 2'h0;
		// RULE7: buffer access codes
		if (atr == `RSWR_ATR_BUF) begin
			case (acc)
				`RSWR_B_IDS, `RSWR_B_RAND, `RSWR_B_RIN, `RSWR_B_ROUT,
				`RSWR_B_RREG, `RSWR_B_LSR, `RSWR_B_LSW: k = 2'h2;
				default: k = 2'h0;
			endcase
		end else if (atr == `RSWR_ATR_DEV) begin
			// RULE8: controller device areas
			case (acc)
				`RSWR_D_IN, `RSWR_D_OUT, `RSWR_D_MREL, `RSWR_D_LAT,
				`RSWR_D_LREL, `RSWR_D_TCON, `RSWR_D_TCOIL,
				`RSWR_D_RTCON, `RSWR_D_RTCOIL, `RSWR_D_CCON,
				`RSWR_D_CCOIL, `RSWR_B_LSR, `RSWR_D_SREL: k = 2'h3;
				`RSWR_D_TPV, `RSWR_D_RTPV, `RSWR_D_CPV, `RSWR_D_DREG,
				`RSWR_D_LREG, `RSWR_D_FREG, `RSWR_B_LSW,
				`RSWR_D_SREG: k = 2'h2;
				default: k = 2'h0;
			endcase
		end
		return k;
	endfunction

	// error code of a command about to start, zero when good
	function automatic logic [15:0] check(rswr_pkg::rswr_regs_s s);
		logic [1:0]  k;
		logic [15:0] c;
		k = kind(s.cw2[7:0], s.cw2[15:8]);
		c = 16'h0000;
		// RULE19: module kind codes
		if (!s.cfg[`RSWR_CFG_IFM]) c = `RSWR_EC_NOT_IFM;
		else if (!s.cfg[`RSWR_CFG_SFM]) c = `RSWR_EC_NOT_SFM;
		// RULE20: unsupported command
		else if (s.cmd != `RSWR_CMD_WRITE) c = `RSWR_EC_UNSUP;
		// RULE21: module base or station out of range
		else if (s.iob > `RSWR_IOB_MAX) c = `RSWR_EC_BADDAT;
		else if (s.cw1 > `RSWR_MAX_STN) c = `RSWR_EC_RANGE;
		// RULE9: pair outside the code sets
		else if (!k[1]) c = `RSWR_EC_BADDEV;
		// RULE5: count within limits and send buffer size
		else if (s.cw4 == 16'h0000 || s.cw4 > 16'(MAXW) ||
			s.cw4 > s.cfg[31:16]) c = `RSWR_EC_RANGE;
		// RULE6: older controller device limit
		else if (s.cfg[`RSWR_CFG_OLD] && s.cw2[7:0] == `RSWR_ATR_DEV &&
			s.cw4 > `RSWR_OLD_CNT) c = `RSWR_EC_RANGE;
		// RULE10: bit start alignment
		else if (k[0] && s.cw3[3:0] != 4'h0) c = `RSWR_EC_BADDAT;
		// RULE20: fewer words staged than the count
		else if (s.wptr < s.cw4[9:0]) c = `RSWR_EC_OPCNT;
		return c;
	endfunction

	assign req      = wb_cyc_i & wb_stb_i & ~s_ff.ack;
	assign go       = req & wb_we_i & wb_sel_i[0] &
		(wb_adr_i == `RSWR_A_CTRL) & wb_dat_i[`RSWR_CTRL_GO];
	assign scan_w   = req & wb_we_i & (wb_adr_i == `RSWR_A_SCAN);
	// RULE11: staging port into the send buffer
	assign buf_we   = req & wb_we_i & (wb_adr_i == `RSWR_A_DATA) &
		~s_ff.busy & (s_ff.wptr < 10'(MAXW));
	assign chk_code = check(s_ff);
	assign ridx     = AW'(s_ff.idx - `RSWR_HDR_LEN);

	// next state of the whole engine
	always_comb begin
		nxt_s = s_ff;
		nxt_s.ack = 1'b0;
		nxt_s.rdy_sy = {s_ff.rdy_sy[0], link_ready};
		nxt_s.rv_sy = {s_ff.rv_sy[0], resp_valid};
		nxt_s.re_sy = {s_ff.re_sy[0], resp_err};
		nxt_s.rv_d = s_ff.rv_sy[1];
		// bus slave: answer one cycle after the request
		if (req) begin
			nxt_s.ack = 1'b1;
			case (wb_adr_i)
				`RSWR_A_CTRL: nxt_s.dat = {16'h0000, s_ff.cmd, 8'h00};
				`RSWR_A_CW0:  nxt_s.dat = {16'h0000, s_ff.cw0};
				`RSWR_A_CW1:  nxt_s.dat = {16'h0000, s_ff.cw1};
				`RSWR_A_CW2:  nxt_s.dat = {16'h0000, s_ff.cw2};
				`RSWR_A_CW3:  nxt_s.dat = {16'h0000, s_ff.cw3};
				`RSWR_A_CW4:  nxt_s.dat = {16'h0000, s_ff.cw4};
				`RSWR_A_IOB:  nxt_s.dat = {16'h0000, s_ff.iob};
				`RSWR_A_CFG:  nxt_s.dat = s_ff.cfg;
				`RSWR_A_STAT: nxt_s.dat = {6'h00, s_ff.wptr, 12'h000,
					s_ff.opf, s_ff.err, s_ff.done, s_ff.busy};
				`RSWR_A_ERRC: nxt_s.dat = {16'h0000, s_ff.opc};
				default:      nxt_s.dat = 32'h0000_0000;
			endcase
			// RULE15: operands locked while a write is outstanding
			if (wb_we_i && !s_ff.busy) begin
				case (wb_adr_i)
					`RSWR_A_CTRL: begin
						if (wb_sel_i[1]) nxt_s.cmd = wb_dat_i[15:8];
						if (wb_sel_i[0] && wb_dat_i[`RSWR_CTRL_REWIND])
							nxt_s.wptr = 10'h000;
					end
					`RSWR_A_CW1: nxt_s.cw1 = 16'(merge(32'(s_ff.cw1),
						wb_dat_i, wb_sel_i));
					// RULE3: codes word merged by byte lane
					`RSWR_A_CW2: nxt_s.cw2 = 16'(merge(32'(s_ff.cw2),
						wb_dat_i, wb_sel_i));
					// RULE4: start address as given, offset from 0
					`RSWR_A_CW3: nxt_s.cw3 = 16'(merge(32'(s_ff.cw3),
						wb_dat_i, wb_sel_i));
					`RSWR_A_CW4: nxt_s.cw4 = 16'(merge(32'(s_ff.cw4),
						wb_dat_i, wb_sel_i));
					`RSWR_A_IOB: nxt_s.iob = 16'(merge(32'(s_ff.iob),
						wb_dat_i, wb_sel_i));
					`RSWR_A_CFG: nxt_s.cfg = merge(s_ff.cfg, wb_dat_i,
						wb_sel_i);
					`RSWR_A_DATA: nxt_s.wptr = buf_we ?
						s_ff.wptr + 10'h001 : s_ff.wptr;
					default: nxt_s.cfg = nxt_s.cfg;
				endcase
			end
			if (wb_we_i && wb_adr_i == `RSWR_A_STAT &&
				wb_sel_i[0] && wb_dat_i[`RSWR_STAT_OPF])
				nxt_s.opf = 1'b0;
		end
		// RULE16: pulses move only at scan end
		if (scan_w) begin
			nxt_s.done = s_ff.pend;
			// RULE17: error rides with done when abnormal
			nxt_s.err = s_ff.pend & s_ff.pend_err;
			nxt_s.pend = 1'b0;
			if (s_ff.pend)
				nxt_s.busy = 1'b0;
		end
		case (s_ff.fsm)
			rswr_pkg::RSWR_IDLE: begin
				if (go && !s_ff.busy) begin
					// RULE18: invalid command flags and records code
					if (chk_code != 16'h0000) begin
						nxt_s.opf = 1'b1;
						nxt_s.opc = chk_code;
					end else begin
						nxt_s.fsm = rswr_pkg::RSWR_SEND;
						nxt_s.idx = 10'h000;
						nxt_s.busy = 1'b1;
					end
				end
			end
			// RULE12: header words then staged data, four-phase
			rswr_pkg::RSWR_SEND: begin
				if (s_ff.lk.valid) begin
					if (s_ff.rdy_sy[1]) begin
						nxt_s.lk.valid = 1'b0;
						if (s_ff.lk.last)
							nxt_s.fsm = rswr_pkg::RSWR_WAIT;
					end
				end else if (!s_ff.rdy_sy[1]) begin
					nxt_s.lk.valid = 1'b1;
					case (s_ff.idx)
						10'h000: nxt_s.lk.word = s_ff.cw1;
						10'h001: nxt_s.lk.word = s_ff.cw2;
						10'h002: nxt_s.lk.word = s_ff.cw3;
						10'h003: nxt_s.lk.word = s_ff.cw4;
						default: nxt_s.lk.word = sbuf[ridx];
					endcase
					nxt_s.lk.last = (s_ff.idx ==
						s_ff.cw4[9:0] + `RSWR_HDR_LEN - 10'h001);
					nxt_s.idx = s_ff.idx + 10'h001;
				end
			end
			// RULE14: finish only on the write complete answer
			rswr_pkg::RSWR_WAIT: begin
				if (s_ff.rv_sy[1] && !s_ff.rv_d) begin
					nxt_s.pend = 1'b1;
					nxt_s.pend_err = s_ff.re_sy[1];
					// RULE23: settled before done
					// RULE1: status word zero or error code
					nxt_s.cw0 = s_ff.re_sy[1] ? `RSWR_EC_REMOTE : 16'h0000;
					nxt_s.fsm = rswr_pkg::RSWR_IDLE;
				end
			end
			default: nxt_s.fsm = rswr_pkg::RSWR_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
			s_ff.cfg <= `RSWR_CFG_RST;
			s_ff.cmd <= `RSWR_CMD_WRITE;
			s_ff.fsm <= rswr_pkg::RSWR_IDLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// send buffer storage
	always_ff @(posedge clk) begin
		if (buf_we) begin
			sbuf[s_ff.wptr[AW-1:0]] <= wb_dat_i[15:0];
		end
	end

	assign wb_ack_o   = s_ff.ack;
	assign wb_dat_o   = s_ff.dat;
	assign link_valid = s_ff.lk.valid;
	assign link_last  = s_ff.lk.last;
	assign link_word  = s_ff.lk.word;
	assign cmd_done   = s_ff.done;
	assign cmd_error  = s_ff.err;
	assign op_error   = s_ff.opf;
	assign busy       = s_ff.busy;

	property p_status_word;
		@(posedge clk) disable iff (!rst_n)
		$rose(s_ff.pend) |-> ((s_ff.cw0 == 16'h0000) == !s_ff.pend_err);
	endproperty
	a_status_word: assert property (p_status_word) // RULE1
		else $error("status word disagrees with outcome");

	property p_done_at_scan;
		@(posedge clk) disable iff (!rst_n)
		$rose(s_ff.done) |-> $past(scan_w) && $past(s_ff.pend);
	endproperty
	a_done_at_scan: assert property (p_done_at_scan) // RULE16
		else $error("done rose outside scan end");

	property p_done_holds;
		@(posedge clk) disable iff (!rst_n)
		s_ff.done && !scan_w |=> s_ff.done;
	endproperty
	a_done_holds: assert property (p_done_holds) // RULE16
		else $error("done fell before next scan end");

	property p_err_with_done;
		@(posedge clk) disable iff (!rst_n)
		s_ff.err |-> s_ff.done && s_ff.cw0 != 16'h0000;
	endproperty
	a_err_with_done: assert property (p_err_with_done) // RULE17
		else $error("error pulse without abnormal done");

	property p_answer_first;
		@(posedge clk) disable iff (!rst_n)
		$rose(s_ff.pend) |-> $past(s_ff.fsm) == rswr_pkg::RSWR_WAIT;
	endproperty
	a_answer_first: assert property (p_answer_first) // RULE14
		else $error("completion without write complete answer");

	property p_bad_cmd;
		@(posedge clk) disable iff (!rst_n)
		go && !s_ff.busy && chk_code != 16'h0000 |=>
			s_ff.opf && s_ff.opc == $past(chk_code) &&
			s_ff.fsm == rswr_pkg::RSWR_IDLE;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) // RULE18
		else $error("invalid command not flagged");

	property p_settled;
		@(posedge clk) disable iff (!rst_n)
		$rose(s_ff.done) |-> $stable(s_ff.cw0);
	endproperty
	a_settled: assert property (p_settled) // RULE23
		else $error("status word changed with done");

	property p_word_hold;
		@(posedge clk) disable iff (!rst_n)
		s_ff.lk.valid && !s_ff.rdy_sy[1] |=>
			s_ff.lk.valid && $stable(s_ff.lk.word);
	endproperty
	a_word_hold: assert property (p_word_hold) // RULE12
		else $error("link word dropped before ready");

	property p_one_out;
		@(posedge clk) disable iff (!rst_n)
		s_ff.busy && req && wb_we_i |=>
			$stable(s_ff.cw1) && $stable(s_ff.cw2) &&
			$stable(s_ff.cw4) && $stable(s_ff.cmd);
	endproperty
	a_one_out: assert property (p_one_out) // RULE15
		else $error("operands changed while outstanding");

	c_normal: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(s_ff.done) && !s_ff.err);
	c_abnormal: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(s_ff.err));
	c_op_error: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(s_ff.opf));
	c_frame_end: cover property (@(posedge clk) disable iff (!rst_n)
		$fell(s_ff.lk.valid) && s_ff.fsm == rswr_pkg::RSWR_WAIT);
	c_busy_start: cover property (@(posedge clk) disable iff (!rst_n)
		go && s_ff.busy);

	property p_start_sends;
		@(posedge clk) disable iff (!rst_n)
		go && !s_ff.busy && chk_code == 16'h0000 |=>
			s_ff.busy && s_ff.fsm == rswr_pkg::RSWR_SEND;
	endproperty
	a_start_sends: assert property (p_start_sends) // RULE12
		else $error("good start did not begin sending");

	property p_busy_ends;
		@(posedge clk) disable iff (!rst_n)
		$rose(s_ff.done) |-> !s_ff.busy;
	endproperty
	a_busy_ends: assert property (p_busy_ends) // RULE16
		else $error("busy still set with done");

endmodule

// ===== sim/rswr_station.sv
`timescale 1ns/1ns
// behavioural remote station on the far side of the link
module rswr_station (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic link_valid,
	input  wire logic link_last,
	input  wire logic fail,
	input  wire logic slow,
	output logic      link_ready,
	output logic      resp_valid,
	output logic      resp_err
);
	logic end_w;

	// word handshake, then the write complete answer
	initial begin
		link_ready = 1'b0;
		resp_valid = 1'b0;
		resp_err = 1'b0;
		forever begin
			@(posedge clk);
			resp_err <= ~resp_err; // no meaning outside an answer
			if (rst_n && link_valid) begin
				repeat (slow ? 6 : 1) @(posedge clk);
				link_ready <= 1'b1;
				end_w = link_last;
				while (link_valid) @(posedge clk);
				link_ready <= 1'b0;
				if (end_w) begin
					resp_err <= fail;
					repeat (4) @(posedge clk);
					resp_valid <= 1'b1;
					repeat (6) @(posedge clk);
					resp_valid <= 1'b0;
				end
			end
		end
	end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ns
`include "rswr_map.svh"
module testbench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic        fail = 1'b0;
	logic        slow = 1'b0;
	logic        ack, lv, ll, rdy, rv, re, done, err, opf, busy;
	logic [31:0] rdat;
	logic [15:0] lw;
	logic [31:0] seed = 32'h8E23_32F1;
	int          n_errors = 0;
	int          num_checks = 0;
	logic [31:0] rq [$];
	logic [15:0] lq [$];
	logic        dq [$];
	logic        got = 1'b0;
	logic        done_d = 1'b0;
	logic [15:0] codes [28] = '{16'h0004, 16'h2004, 16'h2104, 16'h2204,
		16'h2404, 16'h6304, 16'h6404, 16'h0105, 16'h0205, 16'h0305,
		16'h8305, 16'h2305, 16'h0905, 16'h0A05, 16'h0C05, 16'h8905,
		16'h8A05, 16'h8C05, 16'h1105, 16'h1205, 16'h1405, 16'h0405,
		16'h2405, 16'h8405, 16'h6305, 16'h6405, 16'h4305, 16'h4405};

	always #50 clk = ~clk;

	rswr_top u_rswr_top (
		.clk        (clk),
		.rst_n      (rst_n),
		.wb_cyc_i   (cyc),
		.wb_stb_i   (stb),
		.wb_we_i    (we),
		.wb_adr_i   (adr),
		.wb_sel_i   (sel),
		.wb_dat_i   (wdat),
		.wb_ack_o   (ack),
		.wb_dat_o   (rdat),
		.link_valid (lv),
		.link_last  (ll),
		.link_word  (lw),
		.link_ready (rdy),
		.resp_valid (rv),
		.resp_err   (re),
		.cmd_done   (done),
		.cmd_error  (err),
		.op_error   (opf),
		.busy       (busy)
	);
	rswr_station u_rswr_station (
		.clk        (clk),
		.rst_n      (rst_n),
		.link_valid (lv),
		.link_last  (ll),
		.fail       (fail),
		.slow       (slow),
		.link_ready (rdy),
		.resp_valid (rv),
		.resp_err   (re)
	);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		int t;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'b1 && t < 100);
		chk(ack, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask

	// one full write command with a random station and data
	task automatic run_cmd(input logic [15:0] c2, input int n);
		logic [15:0] stn;
		logic [15:0] c3;
		logic        f;
		int          k;
		stn = 16'(rnd() % 32'd65);
		c3 = 16'(rnd()) & 16'hFFF0;
		f = seed[4];
		fail <= f;
		slow <= seed[9];
		wr(`RSWR_A_CTRL, 32'h0000_0102);
		lq.push_back(stn);
		lq.push_back(c2);
		lq.push_back(c3);
		lq.push_back(16'(n));
		for (k = 0; k < n; k++) begin
			lq.push_back(16'(rnd()));
			wr(`RSWR_A_DATA, {16'h0, lq[$]});
		end
		wr(`RSWR_A_CW1, {16'h0, stn});
		wb(1'b1, `RSWR_A_CW2, {16'h0, ~c2[15:8], c2[7:0]}, 4'h1);
		wb(1'b1, `RSWR_A_CW2, {16'h0, c2[15:8], ~c2[7:0]}, 4'h2);
		wr(`RSWR_A_CW3, {16'h0, c3});
		wr(`RSWR_A_CW4, 32'(n));
		wr(`RSWR_A_CTRL, 32'h0000_0101);
		chk(busy, 32'h1);
		wr(`RSWR_A_CW4, 32'h1);
		wr(`RSWR_A_CTRL, 32'h0000_0101);
		wr(`RSWR_A_SCAN, 32'h0);
		rd(`RSWR_A_STAT, (32'(n) << 16) | 32'h1);
		k = 0;
		while (rv !== 1'b1 && k < 5000) begin
			@(posedge clk);
			k++;
		end
		chk(rv, 32'h1);
		repeat (8) @(posedge clk);
		dq.push_back(f);
		wr(`RSWR_A_SCAN, 32'h0);
		chk({done, busy}, 32'h2);
		rd(`RSWR_A_CW0, f ? 32'h4A00 : 32'h0);
		rd(`RSWR_A_STAT, (32'(n) << 16) | (f ? 32'h6 : 32'h2));
		wr(`RSWR_A_SCAN, 32'h0);
		rd(`RSWR_A_STAT, 32'(n) << 16);
	endtask

	// refused start: error code, flag, then clear
	task automatic ec(input logic [15:0] code,
		input logic [31:0] cfg = `RSWR_CFG_RST, input logic [7:0] cmd = 8'h01,
		input logic [15:0] iob = 16'h0040, input logic [15:0] s = 16'h0001,
		input logic [15:0] c2 = 16'h2004, input logic [15:0] c3 = 16'h0000,
		input logic [15:0] n = 16'h0002);
		wr(`RSWR_A_CFG, cfg);
		wr(`RSWR_A_IOB, {16'h0, iob});
		wr(`RSWR_A_CW1, {16'h0, s});
		wr(`RSWR_A_CW2, {16'h0, c2});
		wr(`RSWR_A_CW3, {16'h0, c3});
		wr(`RSWR_A_CW4, {16'h0, n});
		wr(`RSWR_A_CTRL, {16'h0, cmd, 8'h00});
		wr(`RSWR_A_CTRL, {16'h0, cmd, 8'h01});
		rd(`RSWR_A_ERRC, {16'h0, code});
		rd(`RSWR_A_STAT, 32'h0002_0008);
		chk(opf, 32'h1);
		wr(`RSWR_A_STAT, 32'h8);
		rd(`RSWR_A_STAT, 32'h0002_0000);
		chk(opf, 32'h0);
	endtask

	// read data against the oldest note
	always @(posedge clk)
		if (ack === 1'b1 && we === 1'b0)
			chk(rdat, rq.pop_front());

	// frame words as the station takes them
	always @(posedge clk) begin
		if (lv === 1'b1 && rdy === 1'b1 && !got) begin
			got <= 1'b1;
			chk(lw, lq.pop_front());
			chk(ll, lq.size() == 0);
		end else if (lv !== 1'b1)
			got <= 1'b0;
	end

	// completion pulse against the noted outcome
	always @(posedge clk) begin
		done_d <= done;
		if (done === 1'b1 && done_d !== 1'b1)
			chk(err, dq.size() ? dq.pop_front() : 1'bx);
	end

	initial begin
		#5_000_000;
		n_errors++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`RSWR_A_CFG, `RSWR_CFG_RST);
		rd(`RSWR_A_CTRL, 32'h0000_0100);
		rd(`RSWR_A_CW0, 32'h0);
		rd(8'h30, 32'h0);
		wr(`RSWR_A_CTRL, 32'h0000_0102);
		wr(`RSWR_A_DATA, rnd());
		wr(`RSWR_A_DATA, rnd());
		ec(16'h0110, .cfg(32'h01E0_0002));
		ec(16'h2112, .cfg(32'h01E0_0001));
		ec(16'h4002, .cmd(8'h02));
		ec(16'h4100, .iob(16'h00FF));
		ec(16'h4101, .s(16'h0041));
		ec(16'h4004, .c2(16'h2504));
		ec(16'h4004, .c2(16'h3005));
		ec(16'h4004, .c2(16'h2006));
		ec(16'h4101, .n(16'h0000));
		ec(16'h4101, .n(16'h01E1));
		ec(16'h4101, .cfg(32'h0001_0003));
		ec(16'h4101, .cfg(32'h01E0_0007), .c2(16'h0405), .n(16'h000B));
		ec(16'h4100, .c2(16'h0105), .c3(16'h0008));
		ec(16'h4003, .n(16'h0003));
		foreach (codes[i])
			run_cmd(codes[i], 1 + int'(rnd() % 32'd4));
		// ten words to an older controller
		wr(`RSWR_A_CFG, 32'h01E0_0007);
		run_cmd(16'h0405, 10);
		summarize();
	end
endmodule
